/* hw/adcc_ctrl.sv */
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
`include "adcc_map.svh"

// Behaviour
// RULE_01: result bus is enabled only while chip select and read strobe are both low.
// RULE_02: in slave serial mode chip select gates the external serial clock.
// RULE_03: reset input high holds the block in reset and abandons any conversion. In the last conversion cycle the code still loads the result into data.
// RULE_04: falling edge of reset input forces data outputs to all zeros.
// RULE_05: falling edge of reset input clears the configuration register.
// RULE_06: host may tie the reset input to ground when unused.
// RULE_07: sleep request lets a running conversion finish, then blocks new starts.
// RULE_08: digital interface keeps working during power-down.
// RULE_09: convert trigger falling edge enters hold and starts a conversion.
// RULE_10: reference and buffer off controls low enable them; high disables them.
// RULE_11: host keeps buffer enabled whenever the internal reference is used.
// RULE_12: async control pins pass two flip-flops before edge detection.
module adcc_ctrl
   import adcc_pkg::*;
(
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [`ADCC_AW-1:0]    paddr,
   input  wire logic [31:0]            pwdata,
   output logic                        pready,
   output logic [31:0]                 prdata,
   output logic                        pslverr,
   input  wire logic                   cs_n,
   input  wire logic                   rd_n,
   input  wire logic                   conv_reset,
   input  wire logic                   sleep_request,
   input  wire logic                   convert_trigger_n,
   input  wire logic                   straight_binary_select,
   input  wire logic                   intref_off,
   input  wire logic                   refbuf_off,
   input  wire logic                   sclk_in,
   input  wire logic [15:0]            sar_code,
   output logic                        bus_oe,
   output logic                        sclk_gated,
   output logic [15:0]                 data_out,
   output logic                        sample_hold,
   output logic                        intref_en,
   output logic                        refbuf_en
);
   import adcc_pkg::*;

   adcc_regs_t r;
   adcc_regs_t next_r;
   logic       rst_hi;
   logic       rst_fall;
   logic       cnv_fall;
   logic       sleeping;
   logic       access;

   // edge detection only on the second and third stages
   assign rst_hi   = r.s2[`ADCC_PIN_RST];
   assign rst_fall = r.s3[`ADCC_PIN_RST] & ~r.s2[`ADCC_PIN_RST];
   assign cnv_fall = r.s3[`ADCC_PIN_CNV] & ~r.s2[`ADCC_PIN_CNV];
   assign sleeping = r.s2[`ADCC_PIN_SLEEP];
   assign access   = psel & penable;

   // next-state logic for the whole block
   always_comb begin
      next_r    = r;
      next_r.s1 = {sclk_in, refbuf_off, intref_off, straight_binary_select,
                   convert_trigger_n, sleep_request, conv_reset, rd_n, cs_n}; // [RULE_12]
      next_r.s2 = r.s1;                                                    // [RULE_12]
      next_r.s3 = r.s2;
      next_r.bus_oe = ~r.s2[`ADCC_PIN_CS] & ~r.s2[`ADCC_PIN_RD];           // [RULE_01]
      // config port is not gated, only the slave-mode data clock
      next_r.sclk_gated = r.cfg[`ADCC_CFG_SLAVE] & ~r.s2[`ADCC_PIN_CS]
                          & r.s2[`ADCC_PIN_SCLK];                          // [RULE_02]
      next_r.intref_en = ~r.s2[`ADCC_PIN_IREF];                            // [RULE_10]
      next_r.refbuf_en = ~r.s2[`ADCC_PIN_RBUF];                            // [RULE_10]

      // conversion sequencer
      unique case (r.st)
         ADCC_IDLE: begin
            // sleep only blocks new starts, never a running one
            if (cnv_fall & ~sleeping & ~rst_hi) begin                      // [RULE_07]
               next_r.st   = ADCC_CONV;                                    // [RULE_09]
               next_r.hold = 1'b1;                                         // [RULE_09]
               next_r.cnt  = `ADCC_CNT_W'(`ADCC_CONV_CYC - 1);
            end
         end
         ADCC_CONV: begin
            if (r.cnt == '0) begin
               next_r.st   = ADCC_IDLE;
               next_r.hold = 1'b0;
               // low select gives twos complement by inverting the msb
               next_r.data = {sar_code[15] ^ ~r.s2[`ADCC_PIN_SBIN], sar_code[14:0]};
            end else begin
               next_r.cnt = r.cnt - `ADCC_CNT_W'(1);
            end
         end
      endcase
      // reset pin aborts without a result, except in the last conversion cycle where data still loads
      if (rst_hi) begin
         next_r.st   = ADCC_IDLE;                                          // [RULE_03]
         next_r.hold = 1'b0;                                               // [RULE_03]
         next_r.cnt  = '0;
      end

      // apb: pready one cycle into access, write lands on the pready edge
      next_r.pready  = 1'b0;
      next_r.pslverr = 1'b0;
      if (access & r.pready & pwrite & (paddr == `ADCC_OFS_CFG))
         next_r.cfg = pwdata[`ADCC_CFG_W-1:0];                             // [RULE_08]
      if (access & ~r.pready) begin
         next_r.pready = 1'b1;                                             // [RULE_08]
         next_r.prdata = '0;
         unique case (paddr)
            `ADCC_OFS_CFG:    next_r.prdata = {30'h0, r.cfg};
            `ADCC_OFS_STATUS: next_r.prdata = {27'h0, r.intref_en, r.refbuf_en, rst_hi,
                                               sleeping & (r.st == ADCC_IDLE),
                                               r.st == ADCC_CONV};
            `ADCC_OFS_RESULT: next_r.prdata = {16'h0, r.data};
            default:          next_r.pslverr = 1'b1;
         endcase
      end
      // reset edge wins over a coincident config write
      if (rst_fall) begin
         next_r.data = '0;                                                 // [RULE_04]
         next_r.cfg  = `ADCC_CFG_RST;                                      // [RULE_05]
      end
   end

   // one register for all state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r    <= '0;
         r.s1 <= `ADCC_PIN_IDLE;
         r.s2 <= `ADCC_PIN_IDLE;
         r.s3 <= `ADCC_PIN_IDLE;
      end else begin
         r <= next_r;
      end
   end

   assign pready      = r.pready;
   assign prdata      = r.prdata;
   assign pslverr     = r.pslverr;
   assign bus_oe      = r.bus_oe;
   assign sclk_gated  = r.sclk_gated;
   assign data_out    = r.data;
   assign sample_hold = r.hold;
   assign intref_en   = r.intref_en;
   assign refbuf_en   = r.refbuf_en;

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_bus_on;
      (!cs_n && !rd_n) [*4] |-> bus_oe;
   endproperty
   a_bus_on: assert property (p_bus_on) else $error("bus not enabled"); // [RULE_01]

   property p_bus_off;
      cs_n [*4] |-> !bus_oe;
   endproperty
   a_bus_off: assert property (p_bus_off) else $error("bus enabled without select"); // [RULE_01]

   property p_sclk_gate;
      (cs_n || !r.cfg[`ADCC_CFG_SLAVE]) [*4] |-> !sclk_gated;
   endproperty
   a_sclk_gate: assert property (p_sclk_gate) else $error("serial clock not gated"); // [RULE_02]

   property p_abort;
      rst_hi |=> (r.st == ADCC_IDLE) && !sample_hold ##1 (!sample_hold || !$past(rst_hi));
   endproperty
   a_abort: assert property (p_abort) else $error("conversion survived reset"); // [RULE_03]

   property p_zero;
      rst_fall |=> data_out == 16'h0000;
   endproperty
   a_zero: assert property (p_zero) else $error("data not zeroed"); // [RULE_04]

   property p_cfg_clr;
      rst_fall |=> r.cfg == `ADCC_CFG_RST;
   endproperty
   a_cfg_clr: assert property (p_cfg_clr) else $error("config not cleared"); // [RULE_05]

   property p_sleep_block;
      sleeping && (r.st == ADCC_IDLE) |=> !sample_hold;
   endproperty
   a_sleep_block: assert property (p_sleep_block) else $error("start while asleep"); // [RULE_07]

   property p_finish;
      $rose(sample_hold) && !rst_hi |-> ##1 (sample_hold || rst_hi) [*8];
   endproperty
   a_finish: assert property (p_finish) else $error("conversion cut short"); // [RULE_07]

   property p_apb_sleep;
      sleeping && access && !pready |=> pready;
   endproperty
   a_apb_sleep: assert property (p_apb_sleep) else $error("bus dead in sleep"); // [RULE_08]

   property p_start;
      cnv_fall && !sleeping && !rst_hi && (r.st == ADCC_IDLE) |=> sample_hold;
   endproperty
   a_start: assert property (p_start) else $error("no hold after trigger"); // [RULE_09]

   property p_ref;
      intref_off [*4] |-> !intref_en;
   endproperty
   a_ref: assert property (p_ref) else $error("reference not off"); // [RULE_10]

   property p_sync;
      $fell(convert_trigger_n) && (r.st == ADCC_IDLE) |=> !sample_hold;
   endproperty
   a_sync: assert property (p_sync) else $error("trigger bypassed synchroniser"); // [RULE_12]

   c_conv_done: cover property ($fell(sample_hold) && !rst_hi);
   c_abort:     cover property (sample_hold && rst_hi);
   c_sleep_run: cover property (sample_hold && sleeping);
   c_read_res:  cover property (access && pready && paddr == `ADCC_OFS_RESULT);
   c_blocked:   cover property (cnv_fall && sleeping && (r.st == ADCC_IDLE));
endmodule

/* hw/adcc_map.svh */
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH

// apb register byte offsets
`define ADCC_AW          8
`define ADCC_OFS_CFG     8'h00
`define ADCC_OFS_STATUS  8'h04
`define ADCC_OFS_RESULT  8'h08

// configuration field positions and reset value
`define ADCC_CFG_W       2
`define ADCC_CFG_SLAVE   0
`define ADCC_CFG_RST     2'h0

// pin vector positions, all pins pass the same synchroniser
`define ADCC_NPIN        9
`define ADCC_PIN_CS      0
`define ADCC_PIN_RD      1
`define ADCC_PIN_RST     2
`define ADCC_PIN_SLEEP   3
`define ADCC_PIN_CNV     4
`define ADCC_PIN_SBIN    5
`define ADCC_PIN_IREF    6
`define ADCC_PIN_RBUF    7
`define ADCC_PIN_SCLK    8
// idle level of the pins: active-low strobes high
`define ADCC_PIN_IDLE    9'h013

// conversion time
`define ADCC_CLK_MHZ     100
`define ADCC_CONV_NS     3000
`define ADCC_CONV_CYC    ((`ADCC_CONV_NS * `ADCC_CLK_MHZ + 999) / 1000)
`define ADCC_CNT_W       9

`endif

/* hw/adcc_pkg.sv */
package adcc_pkg;
   `include "adcc_map.svh"

   typedef enum logic [0:0] {
      ADCC_IDLE,
      ADCC_CONV
   } adcc_state_t;

   typedef struct packed {
      logic [`ADCC_NPIN-1:0]  s1;
      logic [`ADCC_NPIN-1:0]  s2;
      logic [`ADCC_NPIN-1:0]  s3;
      adcc_state_t            st;
      logic [`ADCC_CNT_W-1:0] cnt;
      logic [15:0]            data;
      logic [`ADCC_CFG_W-1:0] cfg;
      logic                   hold;
      logic                   bus_oe;
      logic                   sclk_gated;
      logic                   intref_en;
      logic                   refbuf_en;
      logic                   pready;
      logic                   pslverr;
      logic [31:0]            prdata;
   } adcc_regs_t;
endpackage

/* verification/adc_control_pins_tb_top.sv */
`timescale 1ns/1ps
module adc_control_pins_tb_top;
   import adcc_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic [15:0] sar_code = 16'hA5C3, data_out;
   logic pready, pslverr, e, cs_n, rd_n, conv_reset, sleep_request, convert_trigger_n;
   logic straight_binary_select, intref_off, refbuf_off, sclk_in, bus_oe, sclk_gated;
   logic sample_hold, intref_en, refbuf_en, pv;
   int fails = 0, samples_checked = 0, cyc = 0, n;
   always #5 pclk = ~pclk;
   adcc_host_model u_host (.pclk(pclk), .cs_n(cs_n), .rd_n(rd_n), .conv_reset(conv_reset),
      .sleep_request(sleep_request), .convert_trigger_n(convert_trigger_n),
      .straight_binary_select(straight_binary_select), .intref_off(intref_off),
      .refbuf_off(refbuf_off), .sclk_in(sclk_in));
   adcc_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .cs_n(cs_n), .rd_n(rd_n), .conv_reset(conv_reset),
      .sleep_request(sleep_request), .convert_trigger_n(convert_trigger_n),
      .straight_binary_select(straight_binary_select), .intref_off(intref_off),
      .refbuf_off(refbuf_off), .sclk_in(sclk_in), .sar_code(sar_code), .bus_oe(bus_oe),
      .sclk_gated(sclk_gated), .data_out(data_out), .sample_hold(sample_hold),
      .intref_en(intref_en), .refbuf_en(refbuf_en));
   task automatic conclude();
      if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // hang guard, well above the three full conversions the run needs
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails++;
         conclude();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      samples_checked++;
      if (g !== x) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   // setup, access, then hold until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      // no cycle count assumed; only the hang guard ends this wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task automatic wt(input int c);
      repeat (c) @(posedge pclk);
   endtask
   // waits for the end of a conversion with a bound
   task automatic done();
      n = 0;
      while (sample_hold !== 1'b0 && n < 400) begin
         @(posedge pclk);
         n++;
      end
   endtask
   task automatic edges();
      n = 0;
      repeat (20) begin
         pv = sclk_gated;
         @(posedge pclk);
         n += (sclk_gated !== pv);
      end
   endtask
   initial begin
      wt(20);
      presetn <= 1;
      wt(2);
      for (int i = 0; i < 4; i++) begin
         u_host.rd(i[1], i[0]);
         wt(5);
         chk(bus_oe, i == 0);
      end
      for (int i = 0; i < 4; i++) begin
         u_host.refs(i[1], i[0]);
         wt(5);
         chk({intref_en, refbuf_en}, {~i[1], ~(i[1] & i[0])});
      end
      apb(1, 8'h00, 32'h1);
      u_host.mode(0, 0, 1);
      u_host.rd(1, 1);
      wt(5);
      edges();
      chk(n, 0);
      u_host.rd(0, 1);
      wt(5);
      edges();
      chk(n > 5, 1);
      u_host.mode(0, 0, 0);
      u_host.rd(1, 1);
      apb(0, 8'h0C, 32'h0);
      chk(e, 1); // unmapped offset is refused
      u_host.trig();
      chk(sample_hold, 1);
      done();
      chk(data_out, 16'hA5C3);
      u_host.trig();
      u_host.mode(1, 0, 0);
      wt(6);
      chk(sample_hold, 0);
      u_host.mode(0, 0, 0);
      wt(6);
      chk(data_out, 0);
      apb(0, 8'h00, 32'h0);
      chk(r, 0);
      sar_code <= 16'h3C5A;
      u_host.trig();
      u_host.mode(0, 1, 0);
      done();
      chk(data_out, 16'h3C5A);
      u_host.trig();
      chk(sample_hold, 0);
      apb(0, 8'h08, 32'h0);
      chk(r, 32'h3C5A);
      apb(0, 8'h04, 32'h0);
      chk(r, 32'h2);
      u_host.mode(0, 1, 1);
      u_host.rd(0, 1);
      wt(5);
      edges();
      chk(n, 0);
      u_host.mode(0, 1, 0);
      u_host.rd(1, 1);
      apb(1, 8'h00, 32'h1);
      apb(0, 8'h00, 32'h0);
      chk(r, 1);
      u_host.mode(0, 0, 0);
      u_host.coding(0);
      wt(3);
      u_host.trig();
      done();
      chk(data_out, 16'hBC5A);
      conclude();
   end
endmodule

/* verification/adcc_host_model.sv */
`timescale 1ns/1ps
module adcc_host_model (
   input  wire logic pclk,
   output logic      cs_n,
   output logic      rd_n,
   output logic      conv_reset,
   output logic      sleep_request,
   output logic      convert_trigger_n,
   output logic      straight_binary_select,
   output logic      intref_off,
   output logic      refbuf_off,
   output logic      sclk_in
);
   logic frame;
   // idle levels; reset pin parked at ground while unused
   initial begin
      {cs_n, rd_n, convert_trigger_n, straight_binary_select} = 4'hF;
      {conv_reset, sleep_request, intref_off, refbuf_off, sclk_in, frame} = 6'h00;
   end
   // serial clock runs only inside a frame, parked low otherwise
   always @(posedge pclk) sclk_in <= frame ? ~sclk_in : 1'b0;
   // fall, then high long enough for the synchroniser to see both levels
   task automatic trig();
      convert_trigger_n <= 1'b0;
      repeat (4) @(posedge pclk);
      convert_trigger_n <= 1'b1;
      repeat (4) @(posedge pclk);
   endtask
   // select and read strobe together open the result bus
   task automatic rd(input logic cs, input logic r);
      cs_n <= cs;
      rd_n <= r;
   endtask
   // buffer is never switched off while the internal reference is on
   task automatic refs(input logic ir, input logic rb);
      intref_off <= ir;
      refbuf_off <= rb & ir;
   endtask
   // output coding: high straight binary, low twos complement
   task automatic coding(input logic sb);
      straight_binary_select <= sb;
   endtask
   task automatic mode(input logic rst, input logic slp, input logic fr);
      conv_reset    <= rst;
      sleep_request <= slp;
      frame         <= fr;
   endtask
endmodule
